// ---- logic/sdwp_core.sv ----
// SDRAM write burst, burst terminate, precharge and refresh logic of the memory device
// Summary of operation
// - First write word taken with WRITE command, one more word each following edge.
// - After a burst ends, data pins stay high-Z and extra input data is dropped.
// - WRITE with auto precharge closes its row once the burst completes.
// - A new WRITE may follow on any edge and replaces the running burst.
// - Burst terminate cuts the latest non-autoprecharge burst; its edge's data is dropped.
// - Clock enable low suspends the next internal clock; no data captured then.
// - High byte mask blocks storage with zero latency; burst continues.
// - READ during a write drops data from that edge and ends the write.
// - Bank accepts no ACTIVE until precharge period, 19 ns, after PRECHARGE.
// - PRECHARGE with address bit ten high closes all banks, else selected bank.
// - PRECHARGE to closed or precharging bank is a no-op; idle banks need ACTIVE.
// - Auto precharge chosen per access by address bit ten, starts at earliest point.
// - Read autoprecharge on bank n interrupted by bank m: bank n precharges at once.
// - Write autoprecharge interrupted by bank m: precharge one recovery time later.
// - Refresh row address comes from an internal counter; address pins ignored.
// - Refresh with clock enable low enters self refresh; inputs except enable ignored.
`timescale 1ns/1ns
module sdwp_core
  import sdwp_pkg::*;
#(
  parameter int BURST_LEN = DEF_BURST_LEN,
  parameter int COL_W     = DEF_COL_W
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    cke,
  input  wire logic                    cs_n,
  input  wire logic                    ras_n,
  input  wire logic                    cas_n,
  input  wire logic                    we_n,
  input  wire logic [ROW_W-1:0]        addr,
  input  wire logic                    bank_select_bit0,
  input  wire logic                    bank_select_bit1,
  input  wire logic [DQ_W-1:0]         dq_in,
  input  wire logic [DQM_W-1:0]        dqm,
  input  wire logic [BANK_W+COL_W-1:0] dbg_addr,
  output logic      [DQ_W-1:0]         dq_out,
  output logic                         dq_oe_n,
  output logic      [NUM_BANKS-1:0]    bank_open,
  output logic      [NUM_BANKS-1:0]    bank_precharging,
  output logic                         write_busy,
  output logic                         self_refresh,
  output logic      [ROW_W-1:0]        refresh_row,
  output logic      [DQ_W-1:0]         dbg_rdata
);
  localparam int IN_W  = 1 + 4 + ROW_W + BANK_W + DQM_W + DQ_W;
  localparam int IDX_W = (BURST_LEN > 1) ? $clog2(BURST_LEN) : 1;
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(BURST_LEN - 1);
  localparam int WR_D1 = int'(WR_CYC) + 1;

  if (BURST_LEN < 1 || BURST_LEN > 2**COL_W || COL_W < 1) begin : g_bad_param
    $error("sdwp_core: burst length or column width out of range");
  end

  // Pin synchroniser; reset loads a deselect with clock enable high, so no false suspend
  localparam logic [IN_W-1:0] PIN_IDLE = {1'b1, 4'hf, {(IN_W-5){1'b0}}};

  logic [IN_W-1:0] s1_ff;
  logic [IN_W-1:0] s2_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_ff <= PIN_IDLE;
      s2_ff <= PIN_IDLE;
    end else begin
      s1_ff <= {cke, cs_n, ras_n, cas_n, we_n, addr, bank_select_bit1, bank_select_bit0,
                dqm, dq_in};
      s2_ff <= s1_ff;
    end
  end

  logic                 cke_s;
  logic [3:0]           pins_s;
  logic [ROW_W-1:0]     a_s;
  logic [BANK_W-1:0]    ba_s;
  logic [DQM_W-1:0]     dqm_s;
  logic [DQ_W-1:0]      dq_s;
  logic                 address_bit_ten;
  logic [COL_W-1:0]     col_s;

  assign {cke_s, pins_s, a_s, ba_s, dqm_s, dq_s} = s2_ff;
  assign address_bit_ten = a_s[ADDR_AP_BIT];
  assign col_s           = a_s[COL_W-1:0];

  logic                   cke_q_ff;
  logic                   self_ref_ff;
  logic                   en;
  sdwp_cmd_t              cmd;
  logic [NUM_BANKS-1:0]   bank_open_ff;
  logic [NUM_BANKS-1:0]   pc_busy_ff;
  logic [CNT_W-1:0]       pc_cnt_ff [NUM_BANKS];
  logic [NUM_BANKS-1:0]   pc_start;
  logic                   wr_busy_ff;
  logic [IDX_W-1:0]       wr_idx_ff;
  logic [BANK_W-1:0]      wr_bank_ff;
  logic [COL_W-1:0]       wr_col_ff;
  logic                   wr_ap_ff;
  logic                   rd_busy_ff;
  logic [IDX_W-1:0]       rd_idx_ff;
  logic [BANK_W-1:0]      rd_bank_ff;
  logic                   rd_ap_ff;
  logic                   last_wr_ff;
  logic                   ap_pend_ff;
  logic [CNT_W-1:0]       ap_cnt_ff;
  logic [BANK_W-1:0]      ap_bank_ff;
  logic [CNT_W-1:0]       rc_cnt_ff;
  logic [CNT_W-1:0]       refi_cnt_ff;
  logic [ROW_W-1:0]       refresh_row_ff;
  logic                   is_wr;
  logic                   is_rd;
  logic                   wr_stop;
  logic                   wr_cont;
  logic                   wr_last;
  logic                   bst_wr;
  logic                   rd_stop;
  logic                   rd_last;
  logic                   ap_sched;
  logic                   ap_fire;
  logic                   rd_ap_start;
  logic                   all_idle;
  logic                   ref_ok;
  logic                   mem_we;
  logic [BANK_W+COL_W-1:0] mem_addr;

  // Internal clock runs only when clock enable was high at the previous edge
  assign en  = cke_q_ff && !self_ref_ff;
  assign cmd = en ? sdwp_decode(pins_s) : CMD_NOP;

  assign is_wr  = (cmd == CMD_WR) && bank_open_ff[ba_s];
  assign is_rd  = (cmd == CMD_RD) && bank_open_ff[ba_s];
  assign bst_wr = (cmd == CMD_BST) && last_wr_ff && !wr_ap_ff;
  assign wr_stop = is_rd || bst_wr ||
                   ((cmd == CMD_PRE) && (address_bit_ten || ba_s == wr_bank_ff));
  assign wr_cont = en && wr_busy_ff && !wr_stop && !is_wr;
  assign wr_last = wr_cont && (wr_idx_ff == LAST_IDX);
  assign rd_stop = is_wr || ((cmd == CMD_BST) && !last_wr_ff && !rd_ap_ff) ||
                   ((cmd == CMD_PRE) && (address_bit_ten || ba_s == rd_bank_ff));
  assign rd_last = en && rd_busy_ff && !rd_stop && !is_rd && (rd_idx_ff == LAST_IDX);

  // Data is stored only with a write command or a live burst edge
  assign mem_we   = is_wr || wr_cont;
  assign mem_addr = is_wr ? {ba_s, col_s}
                          : {wr_bank_ff, wr_col_ff + COL_W'(wr_idx_ff)};

  // Auto precharge of writes: at burst end, or when another bank interrupts
  assign ap_sched = (wr_busy_ff && wr_ap_ff &&
                     (wr_last || ((is_rd || is_wr) && ba_s != wr_bank_ff))) ||
                    (is_wr && address_bit_ten && BURST_LEN == 1);
  assign ap_fire  = ap_pend_ff && (ap_cnt_ff == '0);
  assign rd_ap_start = rd_busy_ff && rd_ap_ff &&
                       (rd_last || ((is_rd || is_wr) && ba_s != rd_bank_ff));

  always_comb begin
    for (int b = 0; b < NUM_BANKS; b++) begin
      pc_start[b] = ((cmd == CMD_PRE) && (address_bit_ten || ba_s == BANK_W'(b)) &&
                     bank_open_ff[b]) ||
                    (ap_fire && ap_bank_ff == BANK_W'(b)) ||
                    (rd_ap_start && rd_bank_ff == BANK_W'(b));
    end
  end

  assign all_idle = (bank_open_ff == '0) && (pc_busy_ff == '0);
  assign ref_ok   = (cmd == CMD_REF) && all_idle && (rc_cnt_ff == '0);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cke_q_ff <= 1'b1;
    end else begin
      cke_q_ff <= cke_s;
    end
  end

  // Write burst tracking
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_busy_ff <= 1'b0;
      wr_idx_ff  <= '0;
      wr_bank_ff <= '0;
      wr_col_ff  <= '0;
      wr_ap_ff   <= 1'b0;
    end else if (is_wr) begin
      wr_busy_ff <= (BURST_LEN > 1);
      wr_idx_ff  <= IDX_W'(1);
      wr_bank_ff <= ba_s;
      wr_col_ff  <= col_s;
      wr_ap_ff   <= address_bit_ten;
    end else if ((en && wr_stop) || wr_last) begin
      wr_busy_ff <= 1'b0;
    end else if (wr_cont) begin
      wr_idx_ff <= wr_idx_ff + IDX_W'(1);
    end
  end

  // Read burst tracking, for termination and concurrent auto precharge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_busy_ff <= 1'b0;
      rd_idx_ff  <= '0;
      rd_bank_ff <= '0;
      rd_ap_ff   <= 1'b0;
    end else if (is_rd) begin
      rd_busy_ff <= (BURST_LEN > 1);
      rd_idx_ff  <= IDX_W'(1);
      rd_bank_ff <= ba_s;
      rd_ap_ff   <= address_bit_ten;
    end else if ((en && rd_stop) || rd_last) begin
      rd_busy_ff <= 1'b0;
    end else if (en && rd_busy_ff) begin
      rd_idx_ff <= rd_idx_ff + IDX_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_wr_ff <= 1'b0;
    end else if (is_wr || is_rd) begin
      last_wr_ff <= is_wr;
    end
  end

  // Write recovery countdown before an automatic precharge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ap_pend_ff <= 1'b0;
      ap_cnt_ff  <= '0;
      ap_bank_ff <= '0;
    end else if (ap_sched) begin
      ap_pend_ff <= 1'b1;
      ap_cnt_ff  <= WR_CYC - CNT_W'(1);
      ap_bank_ff <= wr_busy_ff ? wr_bank_ff : ba_s;
    end else if (ap_fire) begin
      ap_pend_ff <= 1'b0;
    end else if (ap_pend_ff) begin
      ap_cnt_ff <= ap_cnt_ff - CNT_W'(1);
    end
  end

  // Bank open state and precharge period timers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bank_open_ff <= '0;
      pc_busy_ff   <= '0;
      for (int b = 0; b < NUM_BANKS; b++) begin
        pc_cnt_ff[b] <= '0;
      end
    end else begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        if (pc_start[b]) begin
          bank_open_ff[b] <= 1'b0;
          pc_busy_ff[b]   <= 1'b1;
          pc_cnt_ff[b]    <= RP_CYC;
        end else if (pc_busy_ff[b]) begin
          pc_cnt_ff[b] <= pc_cnt_ff[b] - CNT_W'(1);
          if (pc_cnt_ff[b] == CNT_W'(1)) begin
            pc_busy_ff[b] <= 1'b0;
          end
        end else if ((cmd == CMD_ACT) && (ba_s == BANK_W'(b)) && (rc_cnt_ff == '0)) begin
          bank_open_ff[b] <= 1'b1;
        end
      end
    end
  end

  // Auto refresh, self refresh and internal row counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      self_ref_ff <= 1'b0;
    end else if (ref_ok && !cke_s) begin
      self_ref_ff <= 1'b1;
    end else if (self_ref_ff && cke_s) begin
      self_ref_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rc_cnt_ff <= '0;
    end else if (ref_ok && cke_s) begin
      rc_cnt_ff <= RC_CYC;
    end else if (rc_cnt_ff != '0) begin
      rc_cnt_ff <= rc_cnt_ff - CNT_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      refi_cnt_ff    <= '0;
      refresh_row_ff <= '0;
    end else if (ref_ok) begin
      refi_cnt_ff    <= REFI_CYC - CNT_W'(1);
      refresh_row_ff <= refresh_row_ff + ROW_W'(1);
    end else if (self_ref_ff) begin
      if (refi_cnt_ff == '0) begin
        refi_cnt_ff    <= REFI_CYC - CNT_W'(1);
        refresh_row_ff <= refresh_row_ff + ROW_W'(1);
      end else begin
        refi_cnt_ff <= refi_cnt_ff - CNT_W'(1);
      end
    end
  end

  // Write path never drives the data pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dq_out  <= '0;
      dq_oe_n <= 1'b1;
    end else begin
      dq_out  <= '0;
      dq_oe_n <= 1'b1;
    end
  end

  assign bank_open        = bank_open_ff;
  assign bank_precharging = pc_busy_ff;
  assign write_busy       = wr_busy_ff;
  assign self_refresh     = self_ref_ff;
  assign refresh_row      = refresh_row_ff;

  sdwp_mem #(
    .AW(BANK_W + COL_W),
    .DW(DQ_W)
  ) u_mem (
    .clk     (clk),
    .we      (mem_we),
    .waddr   (mem_addr),
    .wdata   (dq_s),
    .wbe     (~dqm_s),
    .raddr   (dbg_addr),
    .rdata_ff(dbg_rdata)
  );

  AST_WR_FIRST: assert property (@(posedge clk) disable iff (rst)
    is_wr && !address_bit_ten |-> mem_we ##1 (wr_busy_ff == (BURST_LEN > 1)))
    else $error("write command did not capture first word");
  AST_WR_IDLE: assert property (@(posedge clk) disable iff (rst)
    !wr_busy_ff && !is_wr |-> !mem_we && dq_oe_n)
    else $error("data stored outside a write burst");
  AST_AP_TIMING: assert property (@(posedge clk) disable iff (rst)
    ap_sched |-> ##WR_D1 pc_busy_ff[ap_bank_ff])
    else $error("auto precharge not started after write recovery");
  AST_BST_DROP: assert property (@(posedge clk) disable iff (rst)
    wr_busy_ff && bst_wr |-> !mem_we ##1 !wr_busy_ff)
    else $error("terminate edge data stored or burst kept running");
  AST_SUSPEND: assert property (@(posedge clk) disable iff (rst)
    !cke_q_ff |-> !mem_we ##1 $stable(wr_idx_ff))
    else $error("data captured while clock suspended");
  AST_MASK_CONT: assert property (@(posedge clk) disable iff (rst)
    wr_cont && !wr_last && (dqm_s != '0) |=> wr_busy_ff && wr_idx_ff == $past(wr_idx_ff) + 1)
    else $error("byte mask disturbed the burst");
  AST_RD_STOP: assert property (@(posedge clk) disable iff (rst)
    is_rd |-> !mem_we ##1 !wr_busy_ff)
    else $error("write continued after read command");
  AST_PRE_ONE: assert property (@(posedge clk) disable iff (rst)
    (cmd == CMD_PRE) && !address_bit_ten && bank_open_ff[ba_s] |=>
      !bank_open_ff[$past(ba_s)] && pc_busy_ff[$past(ba_s)])
    else $error("single bank precharge missed its bank");
  AST_ACT_BLOCK: assert property (@(posedge clk) disable iff (rst)
    (cmd == CMD_ACT) && pc_busy_ff[ba_s] && !pc_start[ba_s] |=> !bank_open_ff[$past(ba_s)])
    else $error("bank opened during precharge period");
  AST_SELF_QUIET: assert property (@(posedge clk) disable iff (rst)
    self_ref_ff |-> !mem_we && (cmd == CMD_NOP))
    else $error("command taken in self refresh");

  COV_WR_BURST: cover property (@(posedge clk) disable iff (rst) wr_last);
  COV_AP_WRITE: cover property (@(posedge clk) disable iff (rst) ap_fire);
  COV_SELF_REF: cover property (@(posedge clk) disable iff (rst) $rose(self_ref_ff));
  COV_AUTO_REF: cover property (@(posedge clk) disable iff (rst) ref_ok && cke_s);
endmodule : sdwp_core

// ---- logic/sdwp_pkg.sv ----
// Constants, command codes and timing counts for the SDRAM write/precharge/refresh block
package sdwp_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_WR_NS       = 14;
  localparam int T_RP_NS       = 19;
  localparam int T_RC_NS       = 67;
  localparam int T_REFI_NS     = 7800;
  localparam int CNT_W         = 8;
  localparam int ROW_W         = 13;
  localparam int BANK_W        = 2;
  localparam int NUM_BANKS     = 4;
  localparam int DQ_W          = 16;
  localparam int DQM_W         = 2;
  localparam int ADDR_AP_BIT   = 10;
  localparam int DEF_BURST_LEN = 4;
  localparam int DEF_COL_W     = 8;

  // Least times round up, longest times round down, never below one cycle
  function automatic int sdwp_cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : sdwp_cyc_up

  function automatic int sdwp_cyc_dn(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : sdwp_cyc_dn

  localparam logic [CNT_W-1:0] WR_CYC   = CNT_W'(sdwp_cyc_up(T_WR_NS));
  localparam logic [CNT_W-1:0] RP_CYC   = CNT_W'(sdwp_cyc_up(T_RP_NS));
  localparam logic [CNT_W-1:0] RC_CYC   = CNT_W'(sdwp_cyc_up(T_RC_NS));
  localparam logic [CNT_W-1:0] REFI_CYC = CNT_W'(sdwp_cyc_dn(T_REFI_NS));

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_RD  = 3'h2,
    CMD_WR  = 3'h3,
    CMD_BST = 3'h4,
    CMD_PRE = 3'h5,
    CMD_REF = 3'h6,
    CMD_MRS = 3'h7
  } sdwp_cmd_t;

  // Pins in order cs_n, ras_n, cas_n, we_n
  function automatic sdwp_cmd_t sdwp_decode(input logic [3:0] p);
    case (p)
      4'h3:    return CMD_ACT;
      4'h5:    return CMD_RD;
      4'h4:    return CMD_WR;
      4'h6:    return CMD_BST;
      4'h2:    return CMD_PRE;
      4'h1:    return CMD_REF;
      4'h0:    return CMD_MRS;
      default: return CMD_NOP;
    endcase
  endfunction : sdwp_decode
endpackage : sdwp_pkg

// ---- logic/sdwp_mem.sv ----
// Byte-maskable storage array with a registered read port
`timescale 1ns/1ns
module sdwp_mem #(
  parameter int AW = 10,
  parameter int DW = 16
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [DW/8-1:0] wbe,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_ff
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    for (int i = 0; i < DW/8; i++) begin
      if (we && wbe[i]) begin
        mem[waddr][i*8 +: 8] <= wdata[i*8 +: 8];
      end
    end
  end

  always_ff @(posedge clk) begin
    rdata_ff <= mem[raddr];
  end
endmodule : sdwp_mem

// ---- verif/sdwp_ctrl_model.sv ----
// Memory controller model driving command, address, clock enable and write data pins
`timescale 1ns/1ns
module sdwp_ctrl_model
  import sdwp_pkg::*;
(
  input  wire logic             clk,
  output logic                  cke,
  output logic                  cs_n,
  output logic                  ras_n,
  output logic                  cas_n,
  output logic                  we_n,
  output logic [ROW_W-1:0]      addr,
  output logic                  bank_select_bit0,
  output logic                  bank_select_bit1,
  output logic [DQ_W-1:0]       dq_in,
  output logic [DQM_W-1:0]      dqm
);
  // Pin codes in order cs_n, ras_n, cas_n, we_n; a single die, so truncation stays on it
  localparam logic [3:0] P_NOP = 4'h7;
  localparam logic [3:0] P_DES = 4'hf;
  localparam logic [3:0] P_ACT = 4'h3;
  localparam logic [3:0] P_WR  = 4'h4;
  localparam logic [3:0] P_PRE = 4'h2;
  localparam logic [3:0] P_REF = 4'h1;

  initial begin
    {cke, cs_n, ras_n, cas_n, we_n} = 5'h17;
    {bank_select_bit1, bank_select_bit0} = 2'h0;
    addr = 13'h0000;
    dq_in = 16'h0000;
    dqm = 2'h3;
  end

  // One cycle of pins, changed just after the rising edge
  task automatic drive(input logic [3:0] p, input logic [1:0] b, input logic [12:0] a,
                       input logic [15:0] d, input logic [1:0] m, input logic ck);
    {cs_n, ras_n, cas_n, we_n} = p;
    {bank_select_bit1, bank_select_bit0} = b;
    addr = a;
    dq_in = d;
    dqm = m;
    cke = ck;
    @(posedge clk);
    #1;
  endtask : drive

  // Released data bus shows the inverse of its last value, masked
  task automatic nop(input int n, input logic ck);
    repeat (n) drive(P_DES, 2'h0, ~addr, ~dq_in, 2'h3, ck);
  endtask : nop

  // Row held open at least the minimum active to precharge span by later tasks
  task automatic act(input logic [1:0] b);
    drive(P_ACT, b, 13'h0123, ~dq_in, 2'h3, 1'b1);
  endtask : act

  // Next command follows after as many cycles as words wanted
  task automatic wr(input logic [1:0] b, input logic [7:0] c, input logic ap, input int n,
                    input logic [15:0] d0, input logic [7:0] mk);
    drive(P_WR, b, {2'h0, ap, 2'h0, c}, d0, mk[1:0], 1'b1);
    for (int i = 1; i < n; i++) begin
      drive(P_NOP, b, addr, d0 + 16'(i), mk[2*i+:2], 1'b1);
    end
  endtask : wr

  task automatic pre(input logic [1:0] b, input logic all);
    nop(int'(WR_CYC), 1'b1);
    drive(P_PRE, b, {2'h0, all, 10'h000}, ~dq_in, 2'h3, 1'b1);
    nop(int'(RP_CYC), 1'b1);
  endtask : pre

  // Only with all banks idle; address pins carry junk since the row comes from inside
  task automatic refresh();
    drive(P_REF, 2'h3, 13'h1abc, ~dq_in, 2'h3, 1'b1);
    nop(int'(RC_CYC) + 1, 1'b1);
  endtask : refresh
endmodule : sdwp_ctrl_model

// ---- verif/tb_top.sv ----
// Self-checking bench for the write, precharge and refresh core
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top
  import sdwp_pkg::*;
;
  logic                    clk;
  logic                    rst;
  logic                    cke;
  logic                    cs_n;
  logic                    ras_n;
  logic                    cas_n;
  logic                    we_n;
  logic [ROW_W-1:0]        addr;
  logic                    bs0;
  logic                    bs1;
  logic [DQ_W-1:0]         dq_in;
  logic [DQM_W-1:0]        dqm;
  logic [BANK_W+7:0]       dbg_addr;
  logic [DQ_W-1:0]         dq_out;
  logic                    dq_oe_n;
  logic [NUM_BANKS-1:0]    bank_open;
  logic [NUM_BANKS-1:0]    bank_precharging;
  logic                    write_busy;
  logic                    self_refresh;
  logic [ROW_W-1:0]        refresh_row;
  logic [DQ_W-1:0]         dbg_rdata;
  int                      fail_count = 0;
  int                      num_checks = 0;
  int                      cycles = 0;

  sdwp_core #(.BURST_LEN(4), .COL_W(8)) i_sdwp_core (
    .clk(clk), .rst(rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .addr(addr), .bank_select_bit0(bs0), .bank_select_bit1(bs1),
    .dq_in(dq_in), .dqm(dqm), .dbg_addr(dbg_addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .bank_open(bank_open), .bank_precharging(bank_precharging), .write_busy(write_busy),
    .self_refresh(self_refresh), .refresh_row(refresh_row), .dbg_rdata(dbg_rdata)
  );

  sdwp_ctrl_model i_sdwp_ctrl_model (
    .clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .addr(addr), .bank_select_bit0(bs0), .bank_select_bit1(bs1), .dq_in(dq_in), .dqm(dqm)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      conclude();
    end
  end

  // Backdoor read; want low means the word must differ from e
  task automatic mem_is(input logic [1:0] b, input logic [7:0] c, input logic [15:0] e,
                        input logic want);
    dbg_addr = {b, c};
    repeat (2) @(posedge clk);
    #1;
    if (want) `CHK(dbg_rdata, e)
    else `CHK(dbg_rdata === e, 1'b0)
  endtask : mem_is

  task automatic t_burst();
    i_sdwp_ctrl_model.act(2'h1);
    i_sdwp_ctrl_model.wr(2'h1, 8'h08, 1'b0, 4, 16'h1100, 8'h00);
    `CHK(write_busy, 1'b1)
    i_sdwp_ctrl_model.wr(2'h1, 8'h08, 1'b0, 4, 16'h22f0, 8'h04);
    i_sdwp_ctrl_model.nop(4, 1'b1);
    `CHK({dq_oe_n, write_busy, dq_out}, 18'h20000)
    mem_is(2'h1, 8'h08, 16'h22f0, 1'b1);
    mem_is(2'h1, 8'h09, 16'h2201, 1'b1);
    mem_is(2'h1, 8'h0b, 16'h22f3, 1'b1);
    mem_is(2'h1, 8'h0c, 16'hdd0c, 1'b0);
  endtask : t_burst

  task automatic t_trunc();
    i_sdwp_ctrl_model.wr(2'h1, 8'h20, 1'b0, 2, 16'h3300, 8'h00);
    i_sdwp_ctrl_model.wr(2'h1, 8'h28, 1'b0, 4, 16'h4400, 8'h00);
    i_sdwp_ctrl_model.wr(2'h1, 8'h30, 1'b0, 2, 16'h5500, 8'h00);
    i_sdwp_ctrl_model.drive(4'h6, 2'h1, 13'h0000, 16'h5502, 2'h0, 1'b1);
    i_sdwp_ctrl_model.wr(2'h1, 8'h40, 1'b0, 2, 16'h6600, 8'h00);
    i_sdwp_ctrl_model.drive(4'h5, 2'h1, 13'h0042, 16'h6602, 2'h0, 1'b1);
    i_sdwp_ctrl_model.nop(3, 1'b1);
    mem_is(2'h1, 8'h21, 16'h3301, 1'b1);
    mem_is(2'h1, 8'h2b, 16'h4403, 1'b1);
    mem_is(2'h1, 8'h31, 16'h5501, 1'b1);
    mem_is(2'h1, 8'h32, 16'h5502, 1'b0);
    mem_is(2'h1, 8'h41, 16'h6601, 1'b1);
    mem_is(2'h1, 8'h42, 16'h6602, 1'b0);
  endtask : t_trunc

  // Clock enable low over word one makes the next cycle a hole in the burst
  task automatic t_suspend();
    i_sdwp_ctrl_model.drive(4'h4, 2'h1, 13'h0050, 16'h7700, 2'h0, 1'b1);
    i_sdwp_ctrl_model.drive(4'h7, 2'h1, 13'h0050, 16'h7701, 2'h0, 1'b0);
    i_sdwp_ctrl_model.drive(4'h7, 2'h1, 13'h0050, 16'hdead, 2'h0, 1'b1);
    i_sdwp_ctrl_model.drive(4'h7, 2'h1, 13'h0050, 16'h7702, 2'h0, 1'b1);
    i_sdwp_ctrl_model.drive(4'h7, 2'h1, 13'h0050, 16'h7703, 2'h0, 1'b1);
    i_sdwp_ctrl_model.nop(3, 1'b1);
    mem_is(2'h1, 8'h52, 16'h7702, 1'b1);
    mem_is(2'h1, 8'h53, 16'h7703, 1'b1);
  endtask : t_suspend

  task automatic t_prech();
    logic seen;
    i_sdwp_ctrl_model.act(2'h2);
    i_sdwp_ctrl_model.wr(2'h2, 8'h00, 1'b1, 4, 16'h9900, 8'h00);
    `CHK(bank_open[2], 1'b1)
    seen = 1'b0;
    repeat (6) begin
      i_sdwp_ctrl_model.nop(1, 1'b1);
      seen |= bank_precharging[2];
    end
    `CHK({bank_open[2], seen}, 2'h1)
    i_sdwp_ctrl_model.drive(4'h2, 2'h2, 13'h0000, 16'h0000, 2'h3, 1'b1);
    seen = 1'b0;
    repeat (4) begin
      i_sdwp_ctrl_model.nop(1, 1'b1);
      seen |= bank_precharging[2];
    end
    `CHK(seen, 1'b0)
    i_sdwp_ctrl_model.wr(2'h2, 8'h70, 1'b0, 1, 16'h8800, 8'h00);
    i_sdwp_ctrl_model.nop(3, 1'b1);
    mem_is(2'h2, 8'h70, 16'h8800, 1'b0);
    i_sdwp_ctrl_model.act(2'h0);
    i_sdwp_ctrl_model.wr(2'h0, 8'h10, 1'b1, 2, 16'haa00, 8'h00);
    i_sdwp_ctrl_model.wr(2'h1, 8'h60, 1'b0, 4, 16'hbb00, 8'h00);
    i_sdwp_ctrl_model.nop(4, 1'b1);
    `CHK(bank_open[1:0], 2'h2)
    mem_is(2'h0, 8'h11, 16'haa01, 1'b1);
    mem_is(2'h1, 8'h60, 16'hbb00, 1'b1);
    i_sdwp_ctrl_model.act(2'h0);
    i_sdwp_ctrl_model.drive(4'h5, 2'h0, 13'h0400, 16'h0000, 2'h3, 1'b1);
    i_sdwp_ctrl_model.nop(1, 1'b1);
    i_sdwp_ctrl_model.wr(2'h1, 8'h68, 1'b0, 1, 16'hcc00, 8'h00);
    i_sdwp_ctrl_model.nop(3, 1'b1);
    `CHK(bank_open[1:0], 2'h2)
    i_sdwp_ctrl_model.act(2'h0);
    i_sdwp_ctrl_model.act(2'h3);
    i_sdwp_ctrl_model.pre(2'h3, 1'b0);
    i_sdwp_ctrl_model.nop(3, 1'b1);
    `CHK(bank_open, 4'h3)
    i_sdwp_ctrl_model.act(2'h3);
    i_sdwp_ctrl_model.drive(4'h2, 2'h3, 13'h0000, 16'h0000, 2'h3, 1'b1);
    i_sdwp_ctrl_model.act(2'h3);
    i_sdwp_ctrl_model.nop(3, 1'b1);
    `CHK(bank_open, 4'h3)
    i_sdwp_ctrl_model.pre(2'h2, 1'b1);
    i_sdwp_ctrl_model.nop(3, 1'b1);
    `CHK(bank_open, 4'h0)
  endtask : t_prech

  task automatic t_refresh();
    logic [ROW_W-1:0] r0;
    int n;
    i_sdwp_ctrl_model.act(2'h0);
    r0 = refresh_row;
    i_sdwp_ctrl_model.drive(4'h1, 2'h0, 13'h0000, 16'h0000, 2'h3, 1'b1);
    i_sdwp_ctrl_model.nop(3, 1'b1);
    `CHK(refresh_row, r0)
    i_sdwp_ctrl_model.pre(2'h0, 1'b0);
    i_sdwp_ctrl_model.nop(2, 1'b1);
    i_sdwp_ctrl_model.refresh();
    i_sdwp_ctrl_model.nop(2, 1'b1);
    `CHK(refresh_row, r0 + 13'h0001)
    i_sdwp_ctrl_model.refresh();
    i_sdwp_ctrl_model.nop(2, 1'b1);
    `CHK(refresh_row, r0 + 13'h0002)
    i_sdwp_ctrl_model.drive(4'h1, 2'h0, 13'h0000, 16'h0000, 2'h3, 1'b0);
    i_sdwp_ctrl_model.nop(3, 1'b0);
    `CHK(self_refresh, 1'b1)
    i_sdwp_ctrl_model.drive(4'h3, 2'h0, 13'h0000, 16'h0000, 2'h3, 1'b0);
    i_sdwp_ctrl_model.nop(3, 1'b0);
    `CHK({self_refresh, bank_open}, 5'h10)
    n = 0;
    while (self_refresh !== 1'b0 && n < 10) begin
      i_sdwp_ctrl_model.nop(1, 1'b1);
      n++;
    end
    `CHK(self_refresh, 1'b0)
    i_sdwp_ctrl_model.nop(int'(RC_CYC) + 1, 1'b1);
  endtask : t_refresh

  initial begin
    rst = 1'b1;
    dbg_addr = 10'h000;
    repeat (20) @(posedge clk);
    #1;
    `CHK({dq_oe_n, bank_open, write_busy, self_refresh}, 7'h40)
    rst = 1'b0;
    t_burst();
    t_trunc();
    t_suspend();
    t_prech();
    t_refresh();
    conclude();
  end
endmodule : tb_top
